// >>> src/sigdec_pkg.sv
// Purpose : constants and types shared by the signal/output command decoder
// Assumes : commands arrive already parsed into an op code, a target index and a value
// Notes   : values are integers; percent in hundredths, volts in microvolts

package sigdec_pkg;

  // ****************************************
  // command op codes
  // ****************************************
  typedef enum logic [4:0] {
    OP_INPUT_TYPE,   // voltage or current input
    OP_VSOURCE,      // a or a-b
    OP_COUPLING,     // ac or dc
    OP_SHIELD,       // float or ground
    OP_VRANGE,       // 1 V .. 10 mV
    OP_CGAIN,        // 1 Mohm or 100 Mohm
    OP_LEVEL,        // signal strength, query only
    OP_SENS,         // sensitivity 0..27
    OP_TRACK,        // dual reference sync filter target
    OP_TCONST,       // time constant 0..21
    OP_ROLLOFF,      // 6..24 dB/oct
    OP_SYNC,         // synchronous filter enable
    OP_ADV,          // advanced filter enable
    OP_NOISE_BANDWIDTH_QUERY,         // noise bandwidth, query only
    OP_CHAN,         // channel display xy / r-theta
    OP_EXPAND,       // expand off/x10/x100
    OP_OFS_EN,       // offset enable
    OP_OFS_PCT,      // offset percent
    OP_AUTO_OFS,     // auto offset, action only
    OP_RATIO,        // ratio enable
    OP_AUX_IN,       // aux input readback, query only
    OP_AUX_OUT       // aux output level
  } sigdec_op_e;

  // ****************************************
  // value limits
  // ****************************************
  localparam int VRANGE_MAX   = 4;
  localparam int LEVEL_MAX    = 4;
  localparam int SENS_MAX     = 27;
  localparam int TCONST_MAX   = 21;
  localparam int ROLLOFF_MAX  = 3;
  localparam int EXPAND_MAX   = 2;
  localparam int OFS_PCT_MAX  = 99999;     // 999.99 percent in 0.01 steps
  localparam int AUX_OUT_MAX  = 10500000;  // 10.5 V in microvolts
  localparam int CHAN_TGT_MAX = 1;         // channel one and two
  localparam int XYR_TGT_MAX  = 2;         // x, y, r; phase is index 3
  localparam int AUX_TGT_MAX  = 3;         // four aux ports
  localparam int UNIT_VOLT_UV = 1000000;   // ratio divisor when ratio is off
  localparam int NOISE_BANDWIDTH_QUERY_SHIFT   = 6;         // rolloff factors are in 64ths

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [2:0] VRANGE_RST  = 3'h0;
  localparam logic [4:0] SENS_RST    = 5'h0;
  localparam logic [4:0] TCONST_RST  = 5'hA;
  localparam logic [1:0] ROLLOFF_RST = 2'h1;

endpackage

// >>> src/sigdec_top.sv
// Purpose : decodes parsed remote commands and queries for the signal path
// Assumes : one command per cycle at most; answer follows one cycle later
// Notes   : every setting is a registered output port

`timescale 1ns/100ps

// Notes on behaviour
// RULE_01: input type 0 voltage, 1 current
// RULE_02: source 0 single-ended, 1 differential
// RULE_03: coupling 0 ac, 1 dc
// RULE_04: shields 0 float, 1 ground
// RULE_05: voltage range indices 0 to 4
// RULE_06: current gain 0 1M, 1 100M
// RULE_07: level query returns 0 to 4
// RULE_08: sensitivity indices 0 to 27
// RULE_09: tracking filter 0 difference, 1 internal
// RULE_10: time constant indices 0 to 21
// RULE_11: rolloff 6 to 24 dB, indices 0-3
// RULE_12: sync and advanced filter off/on
// RULE_13: noise bandwidth ignores sync filter
// RULE_14: channel one/two, rectangular or polar
// RULE_15: expand x/y/r off, x10, x100
// RULE_16: phase never a target of expand/offset/ratio
// RULE_17: offset enable x/y/r off/on
// RULE_18: offset percent within +-999.99, 0.01 steps
// RULE_19: auto offset on x, y or r
// RULE_20: ratio divides by aux 3 or 4
// RULE_21: aux input query, index 0 to 3
// RULE_22: aux output +-10.5 V, readable back
// RULE_23: out-of-range command rejected, setting kept
module sigdec_top (
  input  wire  logic                     clk,
  input  wire  logic                     rst,
  input  wire  logic                     cmd_valid,
  input  wire  logic                     cmd_query,
  input  wire  sigdec_pkg::sigdec_op_e   cmd_op,
  input  wire  logic [1:0]               cmd_target,
  input  wire  logic signed [31:0]       cmd_value,
  input  wire  logic [2:0]               signal_level,
  input  wire  logic [3:0][31:0]         aux_in_uv,
  output logic                           rsp_valid,
  output logic                           rsp_ok,
  output logic [31:0]                    rsp_data,
  output logic                           input_type_select,
  output logic                           voltage_source_select,
  output logic                           input_coupling_select,
  output logic                           shield_ground_select,
  output logic [2:0]                     voltage_range_select,
  output logic                           current_gain_select,
  output logic [4:0]                     sensitivity_select,
  output logic                           dual_tracking_filter_select,
  output logic [4:0]                     time_constant_select,
  output logic [1:0]                     filter_rolloff_select,
  output logic                           sync_filter_enable,
  output logic                           advanced_filter_enable,
  output logic [1:0]                     channel_display_select,
  output logic [2:0][1:0]                output_expand_select,
  output logic [2:0]                     output_offset_enable,
  output logic [2:0][17:0]               output_offset_percent,
  output logic [2:0]                     auto_offset_action,
  output logic [2:0]                     ratio_enable,
  output logic [2:0][31:0]               ratio_divisor_uv,
  output logic [3:0][31:0]               aux_output_level
);
  import sigdec_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic             rsp_valid;   // answer strobe
    logic             rsp_ok;      // command accepted
    logic [31:0]      rsp_data;    // query result
    logic             in_type;     // voltage / current
    logic             vsrc;        // a / a-b
    logic             cpl;         // ac / dc
    logic             gnd;         // float / ground
    logic [2:0]       vrange;      // range index
    logic             cgain;       // gain index
    logic [4:0]       sens;        // sensitivity index
    logic             track;       // dual ref sync target
    logic [4:0]       tconst;      // time constant index
    logic [1:0]       slope;       // rolloff index
    logic             sync;        // sync filter on
    logic             adv;         // advanced filter on
    logic [1:0]       chan;        // per channel: polar when set
    logic [2:0][1:0]  expand;      // per x/y/r
    logic [2:0]       ofs_en;      // per x/y/r
    logic [2:0][17:0] ofs_pct;     // hundredths of a percent
    logic [2:0]       auto_ofs;    // one-cycle action pulses
    logic [2:0]       ratio;       // per x/y/r
    logic [2:0][31:0] ratio_div;   // divisor in microvolts
    logic [3:0][31:0] aux_out;     // microvolts
  } sigdec_state_s;

  sigdec_state_s st_ff;   // registered state
  sigdec_state_s nxt_st;  // next state

  // ****************************************
  // helpers
  // ****************************************
  // shared range test; negative values pass only where lo is negative
  function automatic logic sigdec_in_range(input logic signed [31:0] v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // noise bandwidth in millihertz from time constant and rolloff.
  // sub-millihertz results truncate to zero at the longest time constants.
  function automatic logic [31:0] sigdec_noise_bandwidth_query(input logic [4:0] tc, input logic [1:0] sl);
    logic [31:0] inv;
    logic [5:0]  mult;
    logic [37:0] prod;
    inv = 32'h0;
    mult = 6'h0;
    prod = 38'h0;
    // 1/tau in millihertz for the decade part of the index
    unique case (tc[4:1])
      4'h0: inv = 32'h3B9ACA00;
      4'h1: inv = 32'h05F5E100;
      4'h2: inv = 32'h00989680;
      4'h3: inv = 32'h000F4240;
      4'h4: inv = 32'h000186A0;
      4'h5: inv = 32'h00002710;
      4'h6: inv = 32'h000003E8;
      4'h7: inv = 32'h00000064;
      4'h8: inv = 32'h0000000A;
      4'h9: inv = 32'h00000001;
      default: inv = 32'h0;
    endcase
    // odd indices are three times longer
    if (tc[0]) begin
      inv = inv / 32'h3;
    end
    // 1/4, 1/8, 3/32, 5/64 as 64ths
    unique case (sl)
      2'h0: mult = 6'h10;
      2'h1: mult = 6'h08;
      2'h2: mult = 6'h06;
      2'h3: mult = 6'h05;
    endcase
    prod = {6'h0, inv} * {32'h0, mult};
    return prod[NOISE_BANDWIDTH_QUERY_SHIFT +: 32];
  endfunction

  // ****************************************
  // command decode
  // ****************************************
  // first case finds limits and the current value, second applies a set
  always_comb begin
    int          vmax;      // largest legal value
    int          vmin;      // smallest legal value
    int          tmax;      // largest legal target
    logic        can_set;   // op has a set form
    logic        can_qry;   // op has a query form
    logic [31:0] cur;       // value returned by a query
    logic        ok;        // command accepted
    vmax = 1;
    vmin = 0;
    tmax = 0;
    can_set = 1'b1;
    can_qry = 1'b1;
    cur = 32'h0;
    ok = 1'b0;
    nxt_st = st_ff;
    nxt_st.rsp_valid = cmd_valid;
    nxt_st.rsp_ok = 1'b0;
    nxt_st.rsp_data = 32'h0;
    nxt_st.auto_ofs = 3'h0;
    unique case (cmd_op)
      OP_INPUT_TYPE: cur = {31'h0, st_ff.in_type};  // RULE_01
      OP_VSOURCE:    cur = {31'h0, st_ff.vsrc};     // RULE_02
      OP_COUPLING:   cur = {31'h0, st_ff.cpl};      // RULE_03
      OP_SHIELD:     cur = {31'h0, st_ff.gnd};      // RULE_04
      OP_VRANGE: begin
        vmax = VRANGE_MAX;                          // RULE_05
        cur = {29'h0, st_ff.vrange};
      end
      OP_CGAIN:      cur = {31'h0, st_ff.cgain};    // RULE_06
      OP_LEVEL: begin
        can_set = 1'b0;
        // clamp so an out-of-scale input never reports above overload
        cur = (signal_level > 3'(LEVEL_MAX)) ? 32'(LEVEL_MAX) : {29'h0, signal_level};  // RULE_07
      end
      OP_SENS: begin
        vmax = SENS_MAX;                            // RULE_08
        cur = {27'h0, st_ff.sens};
      end
      OP_TRACK:      cur = {31'h0, st_ff.track};    // RULE_09
      OP_TCONST: begin
        vmax = TCONST_MAX;                          // RULE_10
        cur = {27'h0, st_ff.tconst};
      end
      OP_ROLLOFF: begin
        vmax = ROLLOFF_MAX;                         // RULE_11
        cur = {30'h0, st_ff.slope};
      end
      OP_SYNC:       cur = {31'h0, st_ff.sync};     // RULE_12
      OP_ADV:        cur = {31'h0, st_ff.adv};      // RULE_12
      OP_NOISE_BANDWIDTH_QUERY: begin
        can_set = 1'b0;
        cur = sigdec_noise_bandwidth_query(st_ff.tconst, st_ff.slope);  // RULE_13
      end
      OP_CHAN: begin
        tmax = CHAN_TGT_MAX;                        // RULE_14
        cur = {31'h0, st_ff.chan[cmd_target[0]]};
      end
      OP_EXPAND: begin
        vmax = EXPAND_MAX;
        tmax = XYR_TGT_MAX;                         // RULE_15 RULE_16
        cur = (cmd_target == 2'h3) ? 32'h0 : {30'h0, st_ff.expand[cmd_target]};
      end
      OP_OFS_EN: begin
        tmax = XYR_TGT_MAX;                         // RULE_16 RULE_17
        cur = (cmd_target == 2'h3) ? 32'h0 : {31'h0, st_ff.ofs_en[cmd_target]};
      end
      OP_OFS_PCT: begin
        vmax = OFS_PCT_MAX;
        vmin = -OFS_PCT_MAX;
        tmax = XYR_TGT_MAX;                         // RULE_16 RULE_18
        cur = (cmd_target == 2'h3) ? 32'h0 : 32'(signed'(st_ff.ofs_pct[cmd_target]));
      end
      OP_AUTO_OFS: begin
        tmax = XYR_TGT_MAX;                         // RULE_16 RULE_19
        can_qry = 1'b0;
        // any value is taken: the pulse carries no data
        vmax = 32'h7FFFFFFF;
        vmin = 32'sh80000000;
      end
      OP_RATIO: begin
        tmax = XYR_TGT_MAX;                         // RULE_16
        cur = (cmd_target == 2'h3) ? 32'h0 : {31'h0, st_ff.ratio[cmd_target]};
      end
      OP_AUX_IN: begin
        can_set = 1'b0;
        tmax = AUX_TGT_MAX;
        cur = aux_in_uv[cmd_target];                // RULE_21
      end
      OP_AUX_OUT: begin
        vmax = AUX_OUT_MAX;
        vmin = -AUX_OUT_MAX;
        tmax = AUX_TGT_MAX;
        cur = st_ff.aux_out[cmd_target];            // RULE_22
      end
      // unlisted codes refuse both forms so a query never reads as taken
      default: begin
        can_set = 1'b0;
        can_qry = 1'b0;
      end
    endcase
    // reject bad targets and values, leaving settings untouched
    if (cmd_query) begin
      ok = can_qry && (32'(cmd_target) <= tmax);
    end else begin
      ok = can_set && (32'(cmd_target) <= tmax) && sigdec_in_range(cmd_value, vmin, vmax);  // RULE_23
    end
    if (cmd_valid) begin
      nxt_st.rsp_ok = ok;
      nxt_st.rsp_data = (ok && cmd_query) ? cur : 32'h0;
    end
    // apply an accepted set
    if (cmd_valid && ok && !cmd_query) begin
      unique case (cmd_op)
        OP_INPUT_TYPE: nxt_st.in_type = cmd_value[0];      // RULE_01
        OP_VSOURCE:    nxt_st.vsrc = cmd_value[0];         // RULE_02
        OP_COUPLING:   nxt_st.cpl = cmd_value[0];          // RULE_03
        OP_SHIELD:     nxt_st.gnd = cmd_value[0];          // RULE_04
        OP_VRANGE:     nxt_st.vrange = cmd_value[2:0];     // RULE_05
        OP_CGAIN:      nxt_st.cgain = cmd_value[0];        // RULE_06
        OP_SENS:       nxt_st.sens = cmd_value[4:0];       // RULE_08
        OP_TRACK:      nxt_st.track = cmd_value[0];        // RULE_09
        OP_TCONST:     nxt_st.tconst = cmd_value[4:0];     // RULE_10
        OP_ROLLOFF:    nxt_st.slope = cmd_value[1:0];      // RULE_11
        OP_SYNC:       nxt_st.sync = cmd_value[0];         // RULE_12
        OP_ADV:        nxt_st.adv = cmd_value[0];          // RULE_12
        OP_CHAN:       nxt_st.chan[cmd_target[0]] = cmd_value[0];  // RULE_14
        OP_EXPAND:     nxt_st.expand[cmd_target] = cmd_value[1:0]; // RULE_15
        OP_OFS_EN:     nxt_st.ofs_en[cmd_target] = cmd_value[0];   // RULE_17
        OP_OFS_PCT:    nxt_st.ofs_pct[cmd_target] = cmd_value[17:0];  // RULE_18
        OP_AUTO_OFS:   nxt_st.auto_ofs[cmd_target] = 1'b1;     // RULE_19
        OP_RATIO:      nxt_st.ratio[cmd_target] = cmd_value[0];
        OP_AUX_OUT:    nxt_st.aux_out[cmd_target] = cmd_value;  // RULE_22
        default:       nxt_st.rsp_ok = 1'b0;
      endcase
    end
    // registering the divisor costs one cycle of lag on aux changes
    // ratio divisor: x and y follow aux 3, r follows aux 4; 1 V when off
    for (int k = 0; k < 3; k++) begin
      if (nxt_st.ratio[k]) begin
        nxt_st.ratio_div[k] = (k == 2) ? aux_in_uv[3] : aux_in_uv[2];  // RULE_20
      end else begin
        nxt_st.ratio_div[k] = UNIT_VOLT_UV;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // one register for the whole state keeps reset values in one place
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.vrange <= VRANGE_RST;
      st_ff.sens <= SENS_RST;
      st_ff.tconst <= TCONST_RST;
      st_ff.slope <= ROLLOFF_RST;
      // unity divisor so a ratio-off path passes values through
      st_ff.ratio_div <= {3{UNIT_VOLT_UV}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs, straight from the register
  // ****************************************
  assign rsp_valid                   = st_ff.rsp_valid;
  assign rsp_ok                      = st_ff.rsp_ok;
  assign rsp_data                    = st_ff.rsp_data;
  assign input_type_select           = st_ff.in_type;
  assign voltage_source_select       = st_ff.vsrc;
  assign input_coupling_select       = st_ff.cpl;
  assign shield_ground_select        = st_ff.gnd;
  assign voltage_range_select        = st_ff.vrange;
  assign current_gain_select         = st_ff.cgain;
  assign sensitivity_select          = st_ff.sens;
  assign dual_tracking_filter_select = st_ff.track;
  assign time_constant_select        = st_ff.tconst;
  assign filter_rolloff_select       = st_ff.slope;
  assign sync_filter_enable          = st_ff.sync;
  assign advanced_filter_enable      = st_ff.adv;
  assign channel_display_select      = st_ff.chan;
  assign output_expand_select        = st_ff.expand;
  assign output_offset_enable        = st_ff.ofs_en;
  assign output_offset_percent       = st_ff.ofs_pct;
  assign auto_offset_action          = st_ff.auto_ofs;
  assign ratio_enable                = st_ff.ratio;
  assign ratio_divisor_uv            = st_ff.ratio_div;
  assign aux_output_level            = st_ff.aux_out;

endmodule

// >>> test/sigdec_checker.sv
// Purpose : concurrent checks on the command decoder ports
// Assumes : one clock domain, asynchronous active-high reset
// Notes   : bound onto every decoder instance at the foot of this file
`timescale 1ns/100ps
module sigdec_checker (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   cmd_valid,
  input wire logic                   cmd_query,
  input wire sigdec_pkg::sigdec_op_e cmd_op,
  input wire logic [1:0]             cmd_target,
  input wire logic signed [31:0]     cmd_value,
  input wire logic [3:0][31:0]       aux_in_uv,
  input wire logic                   rsp_valid,
  input wire logic                   rsp_ok,
  input wire logic [4:0]             sensitivity_select,
  input wire logic [4:0]             time_constant_select,
  input wire logic [2:0][1:0]        output_expand_select,
  input wire logic [2:0]             auto_offset_action,
  input wire logic [2:0]             ratio_enable,
  input wire logic [2:0][31:0]       ratio_divisor_uv,
  input wire logic [3:0][31:0]       aux_output_level
);
  import sigdec_pkg::*;
  // ******
  // shared clocking; every check sleeps through reset
  // ******
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic set_v;  // a set, not a query, is taken at this edge
  assign set_v = cmd_valid && !cmd_query;
  // refused commands still answer, so no answer means a lost command
  property p_rsp;
    cmd_valid |=> rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("command not answered");
  property p_sens_set;
    set_v && cmd_op == OP_SENS && cmd_value >= 0 && cmd_value <= 27 |=> rsp_ok && sensitivity_select == $past(cmd_value[4:0]);
  endproperty
  a_sens_set: assert property (p_sens_set) else $error("sensitivity not applied");
  property p_sens_rej;
    set_v && cmd_op == OP_SENS && (cmd_value < 0 || cmd_value > 27) |=> !rsp_ok && $stable(sensitivity_select);
  endproperty
  a_sens_rej: assert property (p_sens_rej) else $error("bad sensitivity taken");
  property p_tc_rej;
    set_v && cmd_op == OP_TCONST && cmd_value > 21 |=> !rsp_ok && $stable(time_constant_select);
  endproperty
  a_tc_rej: assert property (p_tc_rej) else $error("bad time constant taken");
  property p_phase;
    cmd_valid && cmd_target == 2'h3 && cmd_op inside {OP_EXPAND, OP_OFS_EN, OP_OFS_PCT, OP_RATIO}
      |=> !rsp_ok && $stable(output_expand_select) && $stable(ratio_enable);
  endproperty
  a_phase: assert property (p_phase) else $error("phase target taken");
  property p_auto;
    set_v && cmd_op == OP_AUTO_OFS && cmd_target != 2'h3 |=> rsp_ok && auto_offset_action == 3'h1 << $past(cmd_target);
  endproperty
  a_auto: assert property (p_auto) else $error("auto offset pulse wrong");
  // divisor updates with the enable and lags the aux input by one register stage
  property p_ratio;
    ratio_enable[2] |-> ratio_divisor_uv[2] == $past(aux_in_uv[3]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("r ratio divisor wrong");
  property p_aux_out;
    set_v && cmd_op == OP_AUX_OUT && cmd_value > 10500000 |=> !rsp_ok && $stable(aux_output_level);
  endproperty
  a_aux_out: assert property (p_aux_out) else $error("aux level over limit taken");
  c_sens: cover property (set_v && cmd_op == OP_SENS ##1 rsp_ok);
  c_phase: cover property (cmd_valid && cmd_target == 2'h3 && cmd_op == OP_EXPAND);
  c_auto: cover property (auto_offset_action != 3'h0);
endmodule
bind sigdec_top sigdec_checker u_chk (.*);

// >>> test/sigdec_host.sv
// Purpose : model of the remote host issuing parsed commands
// Assumes : tasks are entered at a falling edge of clk
// Notes   : strobe stays up between calls so commands go back to back
`timescale 1ns/100ps
module sigdec_host (
  input  wire logic              clk,
  input  wire logic              rsp_valid,
  input  wire logic              rsp_ok,
  input  wire logic [31:0]       rsp_data,
  output logic                   cmd_valid,
  output logic                   cmd_query,
  output sigdec_pkg::sigdec_op_e cmd_op,
  output logic [1:0]             cmd_target,
  output logic signed [31:0]     cmd_value
);
  import sigdec_pkg::*;
  // port idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_query = 1'b0;
    cmd_op = OP_INPUT_TYPE;
    cmd_target = 2'h0;
    cmd_value = 32'h0;
  end
  // taken at the next rising edge; answer read at the falling edge after it
  task automatic xfer(input logic q, input sigdec_op_e op, input logic [1:0] t, input int v,
                      output logic got, output logic ok, output logic [31:0] d);
    cmd_valid = 1'b1;
    cmd_query = q;
    cmd_op = op;
    cmd_target = t;
    cmd_value = v;
    @(negedge clk);
    got = rsp_valid;
    ok = rsp_ok;
    d = rsp_data;
  endtask
  // release for n cycles; value lines stop showing the last word
  task automatic idle(input int n);
    cmd_valid = 1'b0;
    cmd_value = ~cmd_value;
    repeat (n) @(negedge clk);
  endtask
endmodule

// >>> test/tb_top.sv
// Purpose : self-checking bench for the signal/output command decoder
// Assumes : host model drives commands at falling edges
// Notes   : rows hold set-then-query cases; awkward cases follow by hand
`timescale 1ns/100ps
module tb_top;
  import sigdec_pkg::*;
  typedef struct packed {
    sigdec_op_e  op;  // command
    logic [1:0]  t;   // target index
    int          v;   // value for the set
    logic [1:0]  ok;  // [1] set taken, [0] query taken
    logic [31:0] qd;  // query answer
  } sigdec_row_s;
  localparam logic [3:0][31:0] AUX_V = {32'h44, 32'h33, 32'h22, 32'h11};  // aux inputs, uV
  logic              clk, rst, cmd_valid, cmd_query, rsp_valid, rsp_ok;
  logic              input_type_select, voltage_source_select, input_coupling_select, shield_ground_select;
  logic              current_gain_select, dual_tracking_filter_select, sync_filter_enable, advanced_filter_enable;
  sigdec_op_e        cmd_op;
  logic [1:0]        cmd_target, filter_rolloff_select, channel_display_select;
  logic signed [31:0] cmd_value;
  logic [2:0]        signal_level, voltage_range_select, output_offset_enable, auto_offset_action, ratio_enable;
  logic [4:0]        sensitivity_select, time_constant_select;
  logic [31:0]       rsp_data;
  logic [3:0][31:0]  aux_in_uv, aux_output_level;
  logic [2:0][1:0]   output_expand_select;
  logic [2:0][17:0]  output_offset_percent;
  logic [2:0][31:0]  ratio_divisor_uv;
  int                miscompares = 0;
  int                n_checks = 0;
  sigdec_row_s rows [31] = '{
    '{OP_INPUT_TYPE, 2'h0, 32'h1, 2'h3, 32'h1}, '{OP_INPUT_TYPE, 2'h0, 32'h2, 2'h1, 32'h1},
    '{OP_VSOURCE, 2'h0, 32'h1, 2'h3, 32'h1}, '{OP_COUPLING, 2'h0, 32'h1, 2'h3, 32'h1},
    '{OP_SHIELD, 2'h0, 32'h1, 2'h3, 32'h1}, '{OP_CGAIN, 2'h0, 32'h1, 2'h3, 32'h1},
    '{OP_VRANGE, 2'h0, 32'h4, 2'h3, 32'h4}, '{OP_VRANGE, 2'h0, 32'h5, 2'h1, 32'h4},
    '{OP_LEVEL, 2'h0, 32'h0, 2'h1, 32'h3}, '{OP_TRACK, 2'h0, 32'h1, 2'h3, 32'h1},
    '{OP_SENS, 2'h0, 32'h1B, 2'h3, 32'h1B}, '{OP_SENS, 2'h0, 32'hFFFFFFFF, 2'h1, 32'h1B},
    '{OP_TCONST, 2'h0, 32'h15, 2'h3, 32'h15}, '{OP_TCONST, 2'h0, 32'h16, 2'h1, 32'h15},
    '{OP_ROLLOFF, 2'h0, 32'h3, 2'h3, 32'h3}, '{OP_ROLLOFF, 2'h0, 32'h4, 2'h1, 32'h3},
    '{OP_SYNC, 2'h0, 32'h1, 2'h3, 32'h1}, '{OP_ADV, 2'h0, 32'h1, 2'h3, 32'h1},
    '{OP_CHAN, 2'h1, 32'h1, 2'h3, 32'h1}, '{OP_CHAN, 2'h2, 32'h1, 2'h0, 32'h0},
    '{OP_EXPAND, 2'h2, 32'h2, 2'h3, 32'h2}, '{OP_EXPAND, 2'h3, 32'h1, 2'h0, 32'h0},
    '{OP_OFS_EN, 2'h2, 32'h1, 2'h3, 32'h1}, '{OP_RATIO, 2'h3, 32'h1, 2'h0, 32'h0},
    '{OP_OFS_PCT, 2'h1, 32'h1869F, 2'h3, 32'h1869F}, '{OP_OFS_PCT, 2'h1, 32'h186A0, 2'h1, 32'h1869F},
    '{OP_RATIO, 2'h2, 32'h1, 2'h3, 32'h1}, '{OP_AUX_IN, 2'h1, 32'h5, 2'h1, 32'h22},
    '{OP_AUX_OUT, 2'h3, 32'hA037A0, 2'h3, 32'hA037A0}, '{OP_AUX_OUT, 2'h3, 32'hA037A1, 2'h1, 32'hA037A0},
    '{OP_AUTO_OFS, 2'h0, 32'h0, 2'h2, 32'h0}
  };
  sigdec_top u_dut (.*);
  sigdec_host u_host (.*);
  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // one compare for every 32-bit result; four-state so unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one command through the host model, answer checked at once
  task automatic cmd(input logic q, input sigdec_op_e op, input logic [1:0] t, input int v,
                     input logic eok, input logic [31:0] ed);
    logic        got;
    logic        ok;
    logic [31:0] d;
    u_host.xfer(q, op, t, v, got, ok, d);
    chk("rsp_valid", 32'h1, {31'h0, got});
    chk("rsp_ok", {31'h0, eok}, {31'h0, ok});
    chk("rsp_data", ed, d);
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ******
  // main sequence
  // ******
  initial begin
    rst = 1'b1;
    signal_level = 3'h3;
    aux_in_uv = AUX_V;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      cmd(1'b0, rows[i].op, rows[i].t, rows[i].v, rows[i].ok[1], 32'h0);
      cmd(1'b1, rows[i].op, rows[i].t, 0, rows[i].ok[0], rows[i].qd);
    end
    u_host.idle(1);
    chk("binary settings", 32'hFF, {24'h0, input_type_select, voltage_source_select, input_coupling_select,
        shield_ground_select, current_gain_select, dual_tracking_filter_select, sync_filter_enable,
        advanced_filter_enable});
    chk("range/sens/tc/slope", 32'h4DD7, {17'h0, voltage_range_select, sensitivity_select,
        time_constant_select, filter_rolloff_select});
    chk("chan/expand/offset/ratio", 32'h2824, {18'h0, channel_display_select, output_expand_select,
        output_offset_enable, ratio_enable});
    chk("ratio_divisor_uv r", AUX_V[3], ratio_divisor_uv[2]);
    chk("ratio_divisor_uv x", 32'hF4240, ratio_divisor_uv[0]);
    chk("aux_output_level", 32'hA037A0, aux_output_level[3]);
    // bandwidth at 100 ms: 10 Hz times the slope factor, in millihertz
    cmd(1'b0, OP_TCONST, 2'h0, 10, 1'b1, 32'h0);
    cmd(1'b0, OP_ROLLOFF, 2'h0, 0, 1'b1, 32'h0);
    cmd(1'b1, OP_NOISE_BANDWIDTH_QUERY, 2'h0, 0, 1'b1, 32'h9C4);
    cmd(1'b0, OP_SYNC, 2'h0, 0, 1'b1, 32'h0);
    cmd(1'b1, OP_NOISE_BANDWIDTH_QUERY, 2'h0, 0, 1'b1, 32'h9C4);
    cmd(1'b0, OP_ROLLOFF, 2'h0, 3, 1'b1, 32'h0);
    cmd(1'b1, OP_NOISE_BANDWIDTH_QUERY, 2'h0, 0, 1'b1, 32'h30D);
    for (int l = 0; l < 8; l++) begin
      signal_level = 3'(l);
      cmd(1'b1, OP_LEVEL, 2'h0, 0, 1'b1, (l > 4) ? 32'h4 : 32'(l));
    end
    for (int t = 0; t < 4; t++) begin
      cmd(1'b1, OP_AUX_IN, 2'(t), 0, 1'b1, AUX_V[t]);
    end
    // pulse must drop after one cycle even with a command right behind it
    cmd(1'b0, OP_AUTO_OFS, 2'h1, 0, 1'b1, 32'h0);
    chk("auto_offset_action", 32'h2, {29'h0, auto_offset_action});
    cmd(1'b0, OP_OFS_PCT, 2'h0, -99999, 1'b1, 32'h0);
    chk("auto_offset_action", 32'h0, {29'h0, auto_offset_action});
    chk("output_offset_percent", 32'h27961, {14'h0, output_offset_percent[0]});
    u_host.idle(1);
    // second reset in mid-run, then a command at the first edge after it
    rst = 1'b1;
    @(negedge clk);
    chk("reset settings", 32'h00052, {19'h0, sensitivity_select, time_constant_select, filter_rolloff_select,
        rsp_valid});
    chk("reset divisor", 32'hF4240, ratio_divisor_uv[2]);
    chk("reset aux level", 32'h0, aux_output_level[3]);
    rst = 1'b0;
    cmd(1'b1, OP_SENS, 2'h0, 0, 1'b1, 32'h0);
    final_report;
  end
  // whole run is about 90 cycles; allow well over ten times that
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
endmodule
